// ==== atr_pkg.sv ====
// package: register map, field layout and types of the threshold / channel 0 register bank
// Contract
// - register 07h holds threshold bits 23..8 across its full 16 bits.
// - register 08h bits 15..8 hold threshold bits 7..0, forming one 24-bit signed threshold.
// - register 08h bits 3..0 hold the read-write global dc filter setting, reset zero.
// - register 09h bits 15..6 hold channel 0 phase delay, 10-bit signed modulator cycles, reset zero.
// - channel 0 dc filter off bit 2 at 0 follows the global setting, at 1 bypasses the filter for channel 0 only.
// - channel 0 input select bits 1..0 choose normal pins, shorted, positive or negative dc test signal.
// - register 0Ah holds channel 0 offset bits 23..8 across its full 16 bits.
// - threshold, channel 0 config and offset upper registers reset to all zeros.
// - register 0Bh bits 15..8 hold channel 0 offset bits 7..0.
// - threshold exceedances are counted and a detection is declared once the configured number is reached in a measurement.
package atr_pkg;
   localparam int ATR_ADDR_W = 6;
   // printed offsets are word indices; byte address is four times these
   localparam logic [3:0] ATR_IDX_TH_HIGH = 4'h7;
   localparam logic [3:0] ATR_IDX_TH_LOW = 4'h8;
   localparam logic [3:0] ATR_IDX_CHANNEL0_CONFIG = 4'h9;
   localparam logic [3:0] ATR_IDX_OFS_HIGH = 4'hA;
   localparam logic [3:0] ATR_IDX_OFS_LOW = 4'hB;
   localparam logic [3:0] ATR_IDX_CD_CTRL = 4'hC;
   localparam logic [3:0] ATR_IDX_CD_STAT = 4'hD;
   localparam logic [15:0] ATR_REG_RESET = 16'h0000;
   localparam logic [15:0] ATR_TH_LOW_MASK = 16'hFF0F;
   localparam logic [15:0] ATR_CHANNEL0_CONFIG_MASK = 16'hFFC7;
   localparam logic [15:0] ATR_OFS_LOW_MASK = 16'hFF00;
   localparam logic [15:0] ATR_CD_CTRL_MASK = 16'h0007;
   localparam int ATR_PHASE_LSB = 6;
   localparam int ATR_DCOFF_BIT = 2;
   localparam int ATR_MEAS_LEN = 128;
   typedef enum logic [1:0] {
      ATR_IN_PINS,
      ATR_IN_SHORT,
      ATR_IN_TEST_POS,
      ATR_IN_TEST_NEG
   } atr_input_type;
   typedef struct packed {
      logic [23:0] detect_threshold;
      logic [3:0] dc_filter_setting;
      logic [9:0] chan0_phase_delay;
      logic chan0_dc_filter_off;
      logic [3:0] chan0_dc_filter_eff;
      atr_input_type chan0_input_select;
      logic [23:0] chan0_offset;
   } atr_cfg_type;
endpackage

// ==== atr_detect.sv ====
// current-detect counter: counts exceedances per measurement and flags a detection that holds until reset
`timescale 1ns/10ps
module atr_detect
   import atr_pkg::*;
#(
   parameter int MEAS_LEN = ATR_MEAS_LEN
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic sample_valid,
   input wire logic signed [23:0] sample,
   input wire logic signed [23:0] threshold,
   input wire logic [2:0] num_sel,
   output logic detected,
   output logic [7:0] count
);
   logic [15:0] meas_cnt;
   logic [8:0] need;
   logic over;
   logic [23:0] mag;
   logic [7:0] next_count;
   assign mag = sample[23] ? 24'(-sample) : sample;
   assign over = $signed(mag) > threshold;
   assign need = 9'(1) << num_sel;
   // saturates so a long burst cannot wrap back below the needed count
   assign next_count = (over && count != 8'hFF) ? count + 8'h01 : count;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meas_cnt <= 16'h0000;
         count <= 8'h00;
      end else if (sample_valid) begin
         // new measurement restarts the exceedance count
         if (meas_cnt == 16'(MEAS_LEN - 1)) begin
            meas_cnt <= 16'h0000;
            count <= 8'h00;
         end else begin
            meas_cnt <= meas_cnt + 16'h0001;
            count <= next_count;
         end
      end
   end
   // sticky until cleared by reset; a detection stays visible for software
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         detected <= 1'b0;
      end else if (sample_valid && {1'b0, next_count} >= need) begin
         // looks at the count including this sample, so the last sample of a measurement is not lost
         detected <= 1'b1;
      end
   end
endmodule

// ==== atr_regs.sv ====
// threshold, dc filter and channel 0 configuration register bank on avalon-mm
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/10ps
module atr_regs
   import atr_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ATR_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic sample_valid,
   input wire logic signed [23:0] sample,
   output atr_cfg_type cfg,
   output logic detected
);
   logic [15:0] th_high;
   logic [15:0] th_low;
   logic [15:0] channel0_config;
   logic [15:0] ofs_high;
   logic [15:0] ofs_low;
   logic [15:0] cd_ctrl;
   logic ack;
   logic [3:0] idx;
   logic [7:0] cd_count;
   logic [15:0] wmask;
   logic wr_go;

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] mask);
      merge = (old & ~(mask & wmask)) | (writedata[15:0] & mask & wmask);
   endfunction

   assign idx = address[ATR_ADDR_W-1:2];
   assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
   // one wait cycle per access keeps read data registered
   assign waitrequest = (read | write) & ~ack;
   assign wr_go = write & ~ack;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack <= 1'b0;
      end else begin
         ack <= (read | write) & ~ack;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         th_high <= ATR_REG_RESET;
         th_low <= ATR_REG_RESET;
         channel0_config <= ATR_REG_RESET;
         ofs_high <= ATR_REG_RESET;
         ofs_low <= ATR_REG_RESET;
         cd_ctrl <= ATR_REG_RESET;
      end else if (wr_go) begin
         unique case (idx)
            ATR_IDX_TH_HIGH: th_high <= merge(th_high, 16'hFFFF);
            ATR_IDX_TH_LOW: th_low <= merge(th_low, ATR_TH_LOW_MASK);
            ATR_IDX_CHANNEL0_CONFIG: channel0_config <= merge(channel0_config, ATR_CHANNEL0_CONFIG_MASK);
            ATR_IDX_OFS_HIGH: ofs_high <= merge(ofs_high, 16'hFFFF);
            ATR_IDX_OFS_LOW: ofs_low <= merge(ofs_low, ATR_OFS_LOW_MASK);
            ATR_IDX_CD_CTRL: cd_ctrl <= merge(cd_ctrl, ATR_CD_CTRL_MASK);
            default: ;
         endcase
      end
   end

   // unmapped addresses read zero and writes there are dropped
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         readdata <= 32'h00000000;
      end else if (read & ~ack) begin
         unique case (idx)
            ATR_IDX_TH_HIGH: readdata <= {16'h0000, th_high};
            ATR_IDX_TH_LOW: readdata <= {16'h0000, th_low};
            ATR_IDX_CHANNEL0_CONFIG: readdata <= {16'h0000, channel0_config};
            ATR_IDX_OFS_HIGH: readdata <= {16'h0000, ofs_high};
            ATR_IDX_OFS_LOW: readdata <= {16'h0000, ofs_low};
            ATR_IDX_CD_CTRL: readdata <= {16'h0000, cd_ctrl};
            ATR_IDX_CD_STAT: readdata <= {16'h0000, cd_count, 7'h00, detected};
            default: readdata <= 32'h00000000;
         endcase
      end
   end

   always_comb begin
      cfg.detect_threshold = {th_high, th_low[15:8]};
      cfg.dc_filter_setting = th_low[3:0];
      cfg.chan0_phase_delay = channel0_config[15:ATR_PHASE_LSB];
      cfg.chan0_dc_filter_off = channel0_config[ATR_DCOFF_BIT];
      // zero setting means filter bypassed for channel 0 only
      cfg.chan0_dc_filter_eff = channel0_config[ATR_DCOFF_BIT] ? 4'h0 : th_low[3:0];
      cfg.chan0_input_select = atr_input_type'(channel0_config[1:0]);
      cfg.chan0_offset = {ofs_high, ofs_low[15:8]};
   end

   atr_detect u_detect (
      .clk(clk),
      .rstn(rstn),
      .sample_valid(sample_valid),
      .sample(sample),
      .threshold(cfg.detect_threshold),
      .num_sel(cd_ctrl[2:0]),
      .detected(detected),
      .count(cd_count)
   );
endmodule

// ==== atr_regs_sva.sv ====
// checker on the atr_regs ports
`timescale 1ns/10ps
module atr_chk
   import atr_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ATR_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire atr_cfg_type cfg
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_wr(i); write && waitrequest && address[5:2] == i; endsequence
   property p_thi; s_wr(4'h7) |=> cfg.detect_threshold[23:8] == $past(writedata[15:0]); endproperty
   a_thi: assert property (p_thi) else $error("thi");
   property p_tlo; s_wr(4'h8) |=> cfg.detect_threshold[7:0] == $past(writedata[15:8]); endproperty
   a_tlo: assert property (p_tlo) else $error("tlo");
   property p_dc; s_wr(4'h8) |=> cfg.dc_filter_setting == $past(writedata[3:0]); endproperty
   a_dc: assert property (p_dc) else $error("dc");
   property p_ph; s_wr(4'h9) |=> cfg.chan0_phase_delay == $past(writedata[15:6]); endproperty
   a_ph: assert property (p_ph) else $error("ph");
   property p_eff; cfg.chan0_dc_filter_eff == (cfg.chan0_dc_filter_off ? 4'h0 : cfg.dc_filter_setting); endproperty
   a_eff: assert property (p_eff) else $error("eff");
   property p_ohi; s_wr(4'hA) |=> cfg.chan0_offset[23:8] == $past(writedata[15:0]); endproperty
   a_ohi: assert property (p_ohi) else $error("ohi");
   property p_olo; s_wr(4'hB) |=> cfg.chan0_offset[7:0] == $past(writedata[15:8]); endproperty
   a_olo: assert property (p_olo) else $error("olo");
   property p_rsv; read && !waitrequest && address[5:2] == 4'h9 |-> readdata[5:3] == 3'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("rsv");
endmodule
bind atr_regs atr_chk u_chk (.*);

// ==== adc_threshold_channel0_config_regs_tb_top.sv ====
// bench for the atr register bank
`timescale 1ns/10ps
module adc_threshold_channel0_config_regs_tb_top import atr_pkg::*;;
   logic clk = 0, rstn = 0, read = 0, write = 0, sample_valid = 0, waitrequest, detected;
   logic [5:0] address = '0;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] writedata = '0, readdata;
   logic signed [23:0] sample = 24'sh7FFFFF;
   atr_cfg_type cfg;
   int n_fail = 0, checks = 0;
   atr_regs u_dut (.*);
   initial forever #5 clk = ~clk;
   initial begin
      #20000 n_fail++;
      wrap_up;
   end
   task wrap_up;
      $display("fail %0d checks %0d", n_fail, checks);
      if (n_fail == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) n_fail++;
      if (s !== e) $display("mismatch %0t %h %h", $time, s, e);
   endtask
   task bus(input logic w, input logic [3:0] i, input logic [15:0] d);
      @(posedge clk);
      write <= w;
      read <= !w;
      address <= {i, 2'b00};
      writedata <= 32'(d);
      // no fixed latency assumed; the watchdog ends a hang
      do @(posedge clk); while (waitrequest !== 1'b0);
      read <= 1'b0;
      write <= 1'b0;
      if (!w) chk(readdata, 32'(d));
   endtask
   task pulse;
      sample_valid <= 1'b1;
      @(posedge clk);
      sample_valid <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task t_regs;
      logic [15:0] m [9] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'hFFFF, 16'hFF0F, 16'hFFC7, 16'hFFFF, 16'hFF00};
      for (int i = 0; i < 9; i++) bus(1'b0, 4'(i + 3), 16'h0);
      for (int i = 0; i < 9; i++) bus(1'b1, 4'(i + 3), 16'hFFFF);
      for (int i = 0; i < 9; i++) bus(1'b0, 4'(i + 3), m[i]);
   endtask
   task t_cfg;
      for (int s = 0; s < 8; s++) begin
         bus(1'b1, 4'h9, 16'h8000 | 16'(s));
         chk({cfg.chan0_phase_delay, cfg.chan0_dc_filter_eff, cfg.chan0_input_select},
            32'h8000 | (s < 4 ? 32'h3C : 32'h0) | (s & 3));
      end
   endtask
   task t_pair;
      bus(1'b1, 4'h7, 16'h89AB);
      bus(1'b1, 4'h8, 16'hCD05);
      bus(1'b1, 4'hA, 16'h1357);
      bus(1'b1, 4'hB, 16'h9BFF);
      chk(32'(cfg.detect_threshold), 32'h0089ABCD);
      chk(32'(cfg.dc_filter_setting), 32'h00000005);
      chk(32'(cfg.chan0_offset), 32'h0013579B);
      bus(1'b0, 4'h8, 16'hCD05);
      bus(1'b0, 4'hB, 16'h9B00);
   endtask
   task t_det;
      bus(1'b1, 4'h7, 16'h0001);
      pulse;
      chk(32'(detected), 32'h1);
   endtask
   task t_det2;
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      chk(32'(detected), 32'h0);
      bus(1'b0, 4'h7, 16'h0000);
      bus(1'b1, 4'hC, 16'h0001);
      pulse;
      chk(32'(detected), 32'h0);
      pulse;
      chk(32'(detected), 32'h1);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_regs;
      t_cfg;
      t_pair;
      t_det;
      t_det2;
      wrap_up;
   end
endmodule
